// [core/evgen_pkg.sv]
// Package for the event output generator: event block layout, memory map
// and state type. Assumes a 16-bit processor address and 8-bit write data.
package evgen_pkg;

	// ------------------------------------------------------------
	// Event memory geometry
	// ------------------------------------------------------------
	localparam int unsigned BLOCK_COUNT = 64;
	localparam int unsigned IDX_W = 6;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned LANES = 4;
	localparam int unsigned DELAY_W = 15;

	// ------------------------------------------------------------
	// Processor address map: shared RAM spans e000h..ffffh
	// ------------------------------------------------------------
	localparam logic [2:0] RAM_TOP_BITS = 3'h7; // addr[15:13] of e000h..ffffh
	localparam logic [4:0] BLOCK_PAGE = 5'h00; // addr[12:8]: blocks at e000h..e0ffh
	localparam int unsigned LANE_LSB = 0;
	localparam int unsigned IDX_LSB = 2;

	// ------------------------------------------------------------
	// Field layout of one block word (byte 0 at bits 7:0)
	// ------------------------------------------------------------
	localparam int unsigned F_DATA_LSB = 0; // byte 0: output word
	localparam int unsigned F_NEXT_LSB = 8; // byte 1 [5:0]: next block index
	localparam int unsigned F_ADC_BIT = 14; // byte 1 [6]: start conversion
	localparam int unsigned F_DAC_BIT = 15; // byte 1 [7]: update converter
	localparam int unsigned F_DELAY_LSB = 16; // bytes 2..3 [14:0]: delay count
	localparam int unsigned F_IRQ_BIT = 31; // byte 3 [7]: raise interrupt

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] WAVE_RST = 8'h00;
	localparam logic [DELAY_W-1:0] COUNT_ZERO = 15'h0000;
	localparam logic [DELAY_W-1:0] COUNT_ONE = 15'h0001;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD,
		ST_COUNT
	} evgen_state_t;

endpackage

// [core/evmem_if.sv]
// Carrier between the sequencer and its event block memory.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
interface evmem_if;
	import evgen_pkg::*;

	logic wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [LANES-1:0] wr_lane;
	logic [7:0] wr_byte;
	logic rd_en;
	logic [IDX_W-1:0] rd_idx;
	logic [WORD_W-1:0] rd_word;

	modport mem (input wr_en, wr_idx, wr_lane, wr_byte, rd_en, rd_idx, output rd_word);
	modport ctl (output wr_en, wr_idx, wr_lane, wr_byte, rd_en, rd_idx, input rd_word);
endinterface

// [core/event_block_memory.sv]
// Event block memory: 64 words of 32 bits, byte writes, registered read.
// Assumes one clock; read data appear the cycle after rd_en.
`timescale 1ns/100ps
module event_block_memory (
	input wire logic clock_i, // Event clock
	evmem_if.mem port // Write and read port
);
	import evgen_pkg::*;

	logic [WORD_W-1:0] rd_q;

	// ------------------------------------------------------------
	// Byte-lane banks, one writer process per bank
	// ------------------------------------------------------------
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [7:0] bank [BLOCK_COUNT];

		// Byte write into this lane only
		always_ff @(posedge clock_i) begin
			if (port.wr_en && port.wr_lane[l]) begin
				bank[port.wr_idx] <= port.wr_byte;
			end
		end

		// Registered read of this lane
		always_ff @(posedge clock_i) begin
			if (port.rd_en) begin
				rd_q[l*8 +: 8] <= bank[port.rd_idx];
			end
		end
	end

	assign port.rd_word = rd_q;
endmodule // event_block_memory

// [core/event_output_generator.sv]
// Event output generator: walks a linked chain of event blocks and drives
// an 8-bit wave word plus converter and interrupt pulses on each event.
// Assumes synchronous inputs on clock_i (250 MHz) and the processor keeping
// its stack and data away from the event block area.
`timescale 1ns/100ps
// Behaviour
// - Up to 64 event blocks live in the event memory.
// - Event start copies data and pointer to holding registers, delay to timer.
// - Timer at zero fires the event, then follows the held pointer.
// - All timing comes from the event clock, not from software.
// - An event may start conversion, update converter, or raise interrupt.
// - An 8-bit output word is updated from each event's data.
// - Blocks sit at e000h..e0ffh in shared RAM e000h..ffffh; software keeps regions apart.
module event_output_generator (
	input wire logic clock_i, // Event clock, 250 MHz
	input wire logic srst_i, // Synchronous reset, active high
	input wire logic cpu_we_i, // Processor byte write strobe
	input wire logic [15:0] cpu_addr_i, // Processor byte address
	input wire logic [7:0] cpu_data_i, // Processor write data
	input wire logic run_i, // Level: chain runs while high
	input wire logic [evgen_pkg::IDX_W-1:0] start_idx_i, // First block of chain
	output logic [7:0] wave_o, // Output word, one bit per channel
	output logic adc_start_o, // One-cycle conversion start pulse
	output logic dac_update_o, // One-cycle converter update pulse
	output logic irq_o, // One-cycle interrupt request pulse
	output logic busy_o // Chain active
);
	import evgen_pkg::*;

	evmem_if mif ();

	evgen_state_t state_q;
	logic [7:0] data_q;
	logic [IDX_W-1:0] next_q;
	logic adc_q;
	logic dac_q;
	logic irq_q;
	logic [DELAY_W-1:0] count_q;
	logic fire;
	logic [7:0] wave_q;
	logic adc_start_q;
	logic dac_update_q;
	logic irq_out_q;
	logic busy_q;

	// ------------------------------------------------------------
	// Processor write decode into the block area
	// ------------------------------------------------------------
	assign mif.wr_en = cpu_we_i && (cpu_addr_i[15:13] == RAM_TOP_BITS) && (cpu_addr_i[12:8] == BLOCK_PAGE);
	assign mif.wr_idx = cpu_addr_i[IDX_LSB +: IDX_W];
	assign mif.wr_byte = cpu_data_i;
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		assign mif.wr_lane[l] = (cpu_addr_i[LANE_LSB +: 2] == 2'(l));
	end

	// Block fetch: first block on start, held pointer on each event
	assign fire = (state_q == ST_COUNT) && (count_q == COUNT_ZERO);
	assign mif.rd_en = ((state_q == ST_IDLE) && run_i) || fire;
	assign mif.rd_idx = (state_q == ST_IDLE) ? start_idx_i : next_q;

	// Event block memory, registered read
	event_block_memory u_mem (
		.clock_i(clock_i),
		.port(mif)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i || !run_i) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= ST_LOAD;
				ST_LOAD: state_q <= ST_COUNT;
				ST_COUNT: if (fire) state_q <= ST_LOAD;
			endcase
		end
	end

	// Holding registers and timer load
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			data_q <= WAVE_RST;
			next_q <= '0;
			adc_q <= 1'b0;
			dac_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (state_q == ST_LOAD) begin
			data_q <= mif.rd_word[F_DATA_LSB +: 8];
			next_q <= mif.rd_word[F_NEXT_LSB +: IDX_W];
			adc_q <= mif.rd_word[F_ADC_BIT];
			dac_q <= mif.rd_word[F_DAC_BIT];
			irq_q <= mif.rd_word[F_IRQ_BIT];
		end
	end

	// Countdown timer on the event clock
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			count_q <= COUNT_ZERO;
		end else if (state_q == ST_LOAD) begin
			count_q <= mif.rd_word[F_DELAY_LSB +: DELAY_W];
		end else if (state_q == ST_COUNT && !fire) begin
			count_q <= count_q - COUNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// Event outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			wave_q <= WAVE_RST;
		end else if (fire && run_i) begin
			wave_q <= data_q;
		end
	end

	// Side effects of an event, one cycle each
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			adc_start_q <= 1'b0;
			dac_update_q <= 1'b0;
			irq_out_q <= 1'b0;
		end else begin
			adc_start_q <= fire && run_i && adc_q;
			dac_update_q <= fire && run_i && dac_q;
			irq_out_q <= fire && run_i && irq_q;
		end
	end

	// Busy flag follows the run level one cycle late
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= run_i;
		end
	end

	// Ports straight from their flip-flops
	assign wave_o = wave_q;
	assign adc_start_o = adc_start_q;
	assign dac_update_o = dac_update_q;
	assign irq_o = irq_out_q;
	assign busy_o = busy_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	// Output word
	wave_on_event_a: assert property (fire && run_i |=> wave_o == $past(data_q))
		else $error("wave word not updated from held data");
	wave_steady_a: assert property (!(fire && run_i) |=> $stable(wave_o))
		else $error("wave word changed without an event");

	// Timer and block fetch
	count_steps_a: assert property (state_q == ST_COUNT && !fire && run_i |=>
		count_q == $past(count_q) - COUNT_ONE)
		else $error("timer did not step down by one");
	reload_next_a: assert property (fire && run_i |=> state_q == ST_LOAD ##1
		count_q == $past(mif.rd_word[F_DELAY_LSB +: DELAY_W]))
		else $error("timer not reloaded after terminal count");
	fetch_pointer_a: assert property (fire |-> mif.rd_en && mif.rd_idx == next_q)
		else $error("next block not fetched from held pointer");
	hold_load_a: assert property (state_q == ST_LOAD && run_i |=>
		data_q == $past(mif.rd_word[F_DATA_LSB +: 8]) && next_q == $past(mif.rd_word[F_NEXT_LSB +: IDX_W]))
		else $error("holding registers not loaded");

	// Side pulses
	pulse_cause_a: assert property ($rose(irq_o) || $rose(adc_start_o) || $rose(dac_update_o) |-> $past(fire))
		else $error("side pulse without an event");
	pulse_width_a: assert property (irq_o |=> !irq_o || $past(fire))
		else $error("interrupt pulse too long");
	pulse_flags_a: assert property (fire && run_i |=>
		adc_start_o == $past(adc_q) && dac_update_o == $past(dac_q) && irq_o == $past(irq_q))
		else $error("side pulses do not follow block flags");
	adc_width_a: assert property (adc_start_o |=> !adc_start_o)
		else $error("conversion pulse too long");
	dac_width_a: assert property (dac_update_o |=> !dac_update_o)
		else $error("converter pulse too long");
	halt_quiet_a: assert property (!run_i |=> !adc_start_o && !dac_update_o && !irq_o)
		else $error("side pulse while halted");

	// Write decode
	block_range_a: assert property (mif.wr_en |-> cpu_addr_i[15:8] == 8'he0)
		else $error("write outside block area accepted");

	// ------------------------------------------------------------
	// Event spacing helper: cycles counted since the timer load
	// ------------------------------------------------------------
	logic [DELAY_W-1:0] elapsed_q;
	logic [DELAY_W-1:0] loaded_q;

	// Counts waiting cycles apart from the timer itself
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			elapsed_q <= COUNT_ZERO;
			loaded_q <= COUNT_ZERO;
		end else if (state_q == ST_LOAD) begin
			elapsed_q <= COUNT_ZERO;
			loaded_q <= mif.rd_word[F_DELAY_LSB +: DELAY_W];
		end else if (state_q == ST_COUNT) begin
			elapsed_q <= elapsed_q + COUNT_ONE;
		end
	end

	event_spacing_a: assert property (fire |-> elapsed_q == loaded_q)
		else $error("event not spaced by its delay count");

	// Main scenarios
	chain_event_c: cover property (fire ##1 state_q == ST_LOAD ##1 state_q == ST_COUNT);
	irq_fire_c: cover property (irq_o);
	zero_delay_c: cover property (fire ##2 fire);
	adc_fire_c: cover property (adc_start_o);
	dac_fire_c: cover property (dac_update_o);
endmodule // event_output_generator

// [test/cpu_block_writer.sv]
// Processor-side model: writes one event block as four byte writes.
// Assumes the generator samples writes on clock_i with a synchronous reset.
`timescale 1ns/100ps
module cpu_block_writer (
	input wire logic clock_i, // Event clock
	input wire logic srst_i, // Synchronous reset
	input wire logic req_i, // Level: write the block
	input wire logic [4:0] page_i, // Address page, 5'h00 valid
	input wire logic [evgen_pkg::IDX_W-1:0] idx_i, // Block index
	input wire logic [evgen_pkg::WORD_W-1:0] word_i, // Block contents
	output logic cpu_we_o, // Byte write strobe
	output logic [15:0] cpu_addr_o, // Byte address
	output logic [7:0] cpu_data_o, // Byte data
	output logic done_o // Last byte issued
);
	import evgen_pkg::*;
	logic act_q;
	logic [1:0] lane_q;
	// -------------------------------------------------
	// Byte sequencer; an idle bus shows inverted values
	// -------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			act_q <= 1'b0;
			lane_q <= 2'h0;
			cpu_we_o <= 1'b0;
			cpu_addr_o <= 16'h0000;
			cpu_data_o <= 8'h00;
			done_o <= 1'b0;
		end else if (act_q) begin
			cpu_we_o <= 1'b1;
			cpu_addr_o <= {RAM_TOP_BITS, page_i, idx_i, lane_q};
			cpu_data_o <= word_i[8*lane_q +: 8];
			lane_q <= lane_q + 2'h1;
			act_q <= (lane_q != 2'h3);
			done_o <= (lane_q == 2'h3);
		end else begin
			cpu_we_o <= 1'b0;
			cpu_addr_o <= ~cpu_addr_o;
			cpu_data_o <= ~cpu_data_o;
			done_o <= 1'b0;
			act_q <= req_i & ~done_o;
		end
	end
endmodule // cpu_block_writer

// [test/testbench.sv]
// Self-checking bench for the event output generator.
// Assumes the processor model in cpu_block_writer and the evgen_pkg layout.
`timescale 1ns/100ps
module testbench;
	import evgen_pkg::*;
	typedef struct packed {logic [5:0] idx; logic [7:0] data; logic [2:0] fl; logic [14:0] dly;} row_t;
	row_t rows [5] = '{'{6'h00, 8'ha5, 3'h0, 15'h0005}, '{6'h11, 8'h3c, 3'h4, 15'h0000},
		'{6'h2a, 8'hc3, 3'h2, 15'h0001}, '{6'h3f, 8'h5a, 3'h1, 15'h0014}, '{6'h05, 8'hff, 3'h7, 15'h7fff}};
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic req = 1'b0;
	logic run_i = 1'b0;
	logic [4:0] page = 5'h00;
	logic [5:0] idx = 6'h00;
	logic [5:0] start_idx_i = 6'h00;
	logic [31:0] word = 32'h0;
	logic cpu_we, done, adc_start_o, dac_update_o, irq_o, busy_o;
	logic [15:0] cpu_addr;
	logic [7:0] cpu_data, wave_o;
	logic [7:0] wave_exp = 8'h00;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	initial forever #2 clock_i = ~clock_i;
	cpu_block_writer i_cpu (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .page_i(page), .idx_i(idx),
		.word_i(word), .cpu_we_o(cpu_we), .cpu_addr_o(cpu_addr), .cpu_data_o(cpu_data), .done_o(done));
	event_output_generator i_dut (.clock_i(clock_i), .srst_i(srst_i), .cpu_we_i(cpu_we), .cpu_addr_i(cpu_addr),
		.cpu_data_i(cpu_data), .run_i(run_i), .start_idx_i(start_idx_i), .wave_o(wave_o),
		.adc_start_o(adc_start_o), .dac_update_o(dac_update_o), .irq_o(irq_o), .busy_o(busy_o));
	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [31:0] mk(input logic [5:0] nx, input logic [7:0] dt, input logic [2:0] fl,
		input logic [14:0] d);
		return {fl[0], d, fl[1], fl[2], nx, dt};
	endfunction
	task automatic put(input logic [4:0] pg, input logic [5:0] ix, input logic [31:0] w);
		@(posedge clock_i);
		req <= 1'b1;
		page <= pg;
		idx <= ix;
		word <= w;
		@(posedge clock_i);
		while (done !== 1'b1) @(posedge clock_i);
		req <= 1'b0;
	endtask
	// Event must appear exactly gap edges on, not one earlier
	task automatic see(input logic [7:0] dt, input logic [2:0] fl, input int gap);
		repeat (gap - 1) @(posedge clock_i);
		#1;
		check("wave early", wave_o, wave_exp);
		check("pulses early", {adc_start_o, dac_update_o, irq_o}, 16'h0000);
		@(posedge clock_i);
		#1;
		check("wave", wave_o, dt);
		check("pulses", {adc_start_o, dac_update_o, irq_o}, fl);
		check("busy", busy_o, 1'b1);
		wave_exp = dt;
	endtask
	task automatic go(input logic [5:0] ix);
		@(posedge clock_i);
		run_i <= 1'b1;
		start_idx_i <= ix;
	endtask
	task automatic halt(input logic [7:0] dt);
		@(posedge clock_i);
		run_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		check("busy off", busy_o, 1'b0);
		check("wave held", wave_o, dt);
	endtask
	// Hang guard
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			test_done();
		end
	end
	// -------------------------------------------------
	// Main sequence
	// -------------------------------------------------
	initial begin
		repeat (6) @(posedge clock_i);
		srst_i <= 1'b0;
		#1;
		check("reset outputs", {wave_o, adc_start_o, dac_update_o, irq_o, busy_o}, 16'h0000);
		foreach (rows[i]) begin
			put(5'h00, rows[i].idx, mk(rows[i].idx, rows[i].data, rows[i].fl, rows[i].dly));
			go(rows[i].idx);
			see(rows[i].data, rows[i].fl, rows[i].dly + 3);
			@(posedge clock_i);
			#1;
			check("pulse width", {adc_start_o, dac_update_o, irq_o}, 16'h0000);
			see(rows[i].data, rows[i].fl, rows[i].dly + 1);
			halt(rows[i].data);
		end
		// Two-block chain, pointer followed each way
		put(5'h00, 6'h01, mk(6'h02, 8'h81, 3'h4, 15'h0003));
		put(5'h00, 6'h02, mk(6'h01, 8'h42, 3'h1, 15'h0000));
		go(6'h01);
		see(8'h81, 3'h4, 6);
		see(8'h42, 3'h1, 2);
		see(8'h81, 3'h4, 5);
		see(8'h42, 3'h1, 2);
		halt(8'h42);
		// Write just past the block area must not alter block 1
		put(5'h01, 6'h01, mk(6'h01, 8'h00, 3'h7, 15'h0000));
		go(6'h01);
		see(8'h81, 3'h4, 6);
		halt(8'h81);
		test_done();
	end
endmodule // testbench
